/* gps_pkg.sv */
// Summary of operation
// - Rates 0,300..4800 bps; zero disables receiver.
// - Non-zero rate: carrier pin carries GPS data.
// - Normal polarity reads pin in RS232 sense.
// - Inverted polarity feeds the pin to framing unflipped.
// - Checksum filter drops only failing sentences.
// - Receive only; GPS preconfigured, never transmitted.
// - Rate zero: pin inhibits transmitter keying again.
// - Reset: rate zero, normal, checksum filter.
// - Host GPS mode takes primary port sentences.
// - Acquire off leaves the clock untouched.
// - Valid-only loads clock when flag set.
// - On loads clock from chosen type whatever the flag.
// - Time stage ignores failing checksums always.
// - Same time as last sentence: no update.
// - GGA/GLL sources update time of day only.
// - ZDA has no flag; GLL may lack one.
// - Header match stores up to 128 characters.
package gps_pkg;
	localparam int CLK_HZ    = 200_000_000;
	localparam int BAUD_300  = 300;
	localparam int BAUD_600  = 600;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int CYC_300   = CLK_HZ / BAUD_300;
	localparam int CYC_600   = CLK_HZ / BAUD_600;
	localparam int CYC_1200  = CLK_HZ / BAUD_1200;
	localparam int CYC_2400  = CLK_HZ / BAUD_2400;
	localparam int CYC_4800  = CLK_HZ / BAUD_4800;
	localparam int CYC_W     = 20;
	localparam int LT_LEN    = 128;
	localparam int LT_SLOTS  = 4;
	localparam int HDR_LEN   = 5;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_STAR   = 8'h2a;
	localparam logic [7:0] CH_COMMA  = 8'h2c;
	localparam logic [7:0] CH_CR     = 8'h0d;
	localparam logic [7:0] CH_LF     = 8'h0a;
	localparam logic [7:0] CH_A      = 8'h41;
	localparam logic [7:0] CH_ZERO   = 8'h30;
	localparam logic [4:0] FLD_TIME     = 5'h01;
	localparam logic [4:0] FLD_TIME_GLL = 5'h05;
	localparam logic [4:0] FLD_FLAG_RMC = 5'h02;
	localparam logic [4:0] FLD_FLAG_GX  = 5'h06;
	localparam logic [4:0] FLD_DATE_RMC = 5'h09;
	localparam logic [4:0] FLD_DAY_ZDA  = 5'h02;
	localparam logic [4:0] FLD_YEAR_ZDA = 5'h04;
	localparam logic [2:0] DIGITS = 3'h6;
	typedef enum logic [2:0] {
		RATE_OFF = 3'h0, RATE_300 = 3'h1, RATE_600 = 3'h2,
		RATE_1200 = 3'h3, RATE_2400 = 3'h4, RATE_4800 = 3'h5
	} rate_t;
	typedef enum logic [1:0] {
		TM_OFF = 2'h0, TM_VALID = 2'h1, TM_ON = 2'h2
	} tmode_t;
	typedef enum logic [1:0] {
		ST_GGA = 2'h0, ST_GLL = 2'h1, ST_RMC = 2'h2, ST_ZDA = 2'h3
	} stype_t;
	typedef struct packed {
		rate_t rate;
		logic  inverted;
		logic  skip_sum_check;
	} aux_gps_port_config_t;
	typedef struct packed {
		tmode_t mode;
		stype_t src;
	} time_acquire_mode_t;
	typedef struct packed {
		logic [23:0] hhmmss;
		logic [23:0] ddmmyy;
	} gps_time_t;
	localparam aux_gps_port_config_t PORT_CFG_RST = '{RATE_OFF, 1'b0, 1'b0};
	localparam time_acquire_mode_t TIME_CFG_RST = '{TM_VALID, ST_RMC};
endpackage : gps_pkg

/* uart_char_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_char_rx
	import gps_pkg::*;
(
	input  wire logic             clk_in,         // System clock
	input  wire logic             nrst_in,        // Async reset, low
	input  wire logic             en_in,          // Receiver enable
	input  wire logic             rx_in,          // Line, 1 is idle mark
	input  wire logic [CYC_W-1:0] bit_cyc_in,     // Clocks per bit
	output logic                  char_valid_out, // Character pulse
	output logic [7:0]            char_out        // Received character
);
	typedef enum logic [1:0] {
		RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h2, RX_STOP = 2'h3
	} rx_state_t;
	rx_state_t        state_reg;
	logic [CYC_W-1:0] cnt_reg;
	logic [2:0]       bit_reg;
	logic [7:0]       shift_reg;
	wire              tick = (cnt_reg == '0);

	// -------------------------------------------------------------
	// Framing: start, eight data bits LSB first, one stop bit.
	// -------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_reg      <= RX_IDLE;
			cnt_reg        <= '0;
			bit_reg        <= 3'h0;
			shift_reg      <= 8'h00;
			char_valid_out <= 1'b0;
			char_out       <= 8'h00;
		end
		else
		begin
			char_valid_out <= 1'b0;
			if (!tick)
				cnt_reg <= cnt_reg - 1'b1;
			if (!en_in)
				state_reg <= RX_IDLE;
			else
			begin
				unique case (state_reg)
					RX_IDLE:
						if (!rx_in)
						begin
							// Half a bit lands the samples mid-bit.
							cnt_reg   <= bit_cyc_in >> 1;
							state_reg <= RX_START;
						end
					RX_START:
						if (tick)
						begin
							cnt_reg   <= bit_cyc_in - 1'b1;
							bit_reg   <= 3'h0;
							state_reg <= rx_in ? RX_IDLE : RX_DATA;
						end
					RX_DATA:
						if (tick)
						begin
							shift_reg <= {rx_in, shift_reg[7:1]};
							cnt_reg   <= bit_cyc_in - 1'b1;
							bit_reg   <= bit_reg + 1'b1;
							if (bit_reg == 3'h7)
								state_reg <= RX_STOP;
						end
					RX_STOP:
						if (tick)
						begin
							// A missing stop bit drops the character.
							char_valid_out <= rx_in;
							char_out       <= shift_reg;
							state_reg      <= RX_IDLE;
						end
				endcase
			end
		end
	end
endmodule : uart_char_rx
`default_nettype wire

/* gps_serial_time_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_serial_time_receiver
	import gps_pkg::*;
#(
	parameter int BIT_CYC_300  = CYC_300,
	parameter int BIT_CYC_600  = CYC_600,
	parameter int BIT_CYC_1200 = CYC_1200,
	parameter int BIT_CYC_2400 = CYC_2400,
	parameter int BIT_CYC_4800 = CYC_4800
)
(
	input  wire logic                 clk_in,            // 200 MHz clock
	input  wire logic                 nrst_in,           // Async reset, low
	input  wire logic                 aux_carrier_input_in, // Radio port pin
	input  wire aux_gps_port_config_t port_cfg_in,       // New port setup
	input  wire time_acquire_mode_t   time_cfg_in,       // New time setup
	input  wire logic                 cfg_load_in,       // Load both setups
	input  wire logic                 host_gps_mode_in,  // Host mode is GPS
	input  wire logic                 prim_char_valid_in, // Primary char
	input  wire logic [7:0]           prim_char_in,      // Primary data
	input  wire logic [LT_SLOTS-1:0][HDR_LEN*8-1:0] hdr_in, // Headers
	input  wire logic [1:0]           lt_sel_in,         // Buffer to read
	input  wire logic [6:0]           lt_idx_in,         // Character index
	output logic                      ptt_inhibit_out,   // Keying inhibit
	output logic [7:0]                lt_data_out,       // Read character
	output logic [7:0]                lt_len_out,        // Buffer length
	output logic                      sent_pass_out,     // Sentence passed
	output logic                      sent_drop_out,     // Sentence dropped
	output logic                      clk_set_out,       // Clock load pulse
	output logic                      clk_date_set_out,  // Date load too
	output gps_time_t                 clk_time_out,      // BCD time, date
	output aux_gps_port_config_t      port_cfg_out,      // Active port setup
	output time_acquire_mode_t        time_cfg_out       // Active time setup
);
	aux_gps_port_config_t port_cfg_reg;
	time_acquire_mode_t   time_cfg_reg;
	logic [CYC_W-1:0]     bit_cyc;
	logic                 uart_v;
	logic [7:0]           uart_c;
	logic                 char_v;
	logic [7:0]           char_c;
	logic                 in_sent_reg;
	logic                 star_reg;
	logic [1:0]           hex_cnt_reg;
	logic [7:0]           rx_sum_reg;
	logic [7:0]           sum_reg;
	logic [4:0]           fld_reg;
	logic [6:0]           pos_reg;
	logic [7:0]           len_reg;
	logic [HDR_LEN*8-1:0] hdr_reg;
	logic [LT_LEN-1:0][7:0] line_reg;
	logic [LT_SLOTS-1:0][LT_LEN-1:0][7:0] lt_reg;
	logic [LT_SLOTS-1:0][7:0] lt_len_reg;
	logic [23:0]          time_reg;
	logic [23:0]          date_reg;
	logic [23:0]          last_time_reg;
	logic [2:0]           tcnt_reg;
	logic [2:0]           dcnt_reg;
	logic                 flag_seen_reg;
	logic [7:0]           flag_reg;
	wire                  uart_en = (port_cfg_reg.rate != RATE_OFF)
	                                && !host_gps_mode_in;

	// -------------------------------------------------------------
	// Setup registers and the carrier pin's two roles.
	// -------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			port_cfg_reg <= PORT_CFG_RST;
			time_cfg_reg <= TIME_CFG_RST;
		end
		else if (cfg_load_in)
		begin
			port_cfg_reg <= port_cfg_in;
			time_cfg_reg <= time_cfg_in;
		end
	end
	assign port_cfg_out = port_cfg_reg;
	assign time_cfg_out = time_cfg_reg;

	// With the rate at zero the pin goes back to gating keying.
	assign ptt_inhibit_out = (port_cfg_reg.rate == RATE_OFF)
	                         && aux_carrier_input_in;

	always_comb
	begin
		unique case (port_cfg_reg.rate)
			RATE_300:  bit_cyc = CYC_W'(BIT_CYC_300);
			RATE_600:  bit_cyc = CYC_W'(BIT_CYC_600);
			RATE_1200: bit_cyc = CYC_W'(BIT_CYC_1200);
			RATE_2400: bit_cyc = CYC_W'(BIT_CYC_2400);
			RATE_4800: bit_cyc = CYC_W'(BIT_CYC_4800);
			default:   bit_cyc = CYC_W'(BIT_CYC_4800);
		endcase
	end

	// An idle RS232 line sits at the low pin level, hence the flip.
	// The port has no transmit path at all.
	uart_char_rx u_rx (
		.clk_in         (clk_in),
		.nrst_in        (nrst_in),
		.en_in          (uart_en),
		.rx_in          (aux_carrier_input_in ^ !port_cfg_reg.inverted),
		.bit_cyc_in     (bit_cyc),
		.char_valid_out (uart_v),
		.char_out       (uart_c)
	);

	// Host GPS mode reads sentences from the primary port.
	assign char_v = host_gps_mode_in ? prim_char_valid_in : uart_v;
	assign char_c = host_gps_mode_in ? prim_char_in : uart_c;

	// -------------------------------------------------------------
	// Sentence parser.
	// -------------------------------------------------------------
	wire is_end   = char_v && in_sent_reg
	                && (char_c == CH_CR || char_c == CH_LF);
	wire sum_ok   = !star_reg
	                || (hex_cnt_reg == 2'h2 && rx_sum_reg == sum_reg);
	wire pass     = sum_ok || port_cfg_reg.skip_sum_check;
	wire [3:0] hex_val = char_c[6] ? char_c[3:0] + 4'h9 : char_c[3:0];

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			in_sent_reg <= 1'b0;
			star_reg    <= 1'b0;
			hex_cnt_reg <= 2'h0;
			rx_sum_reg  <= 8'h00;
			sum_reg     <= 8'h00;
			fld_reg     <= 5'h00;
			pos_reg     <= 7'h00;
			len_reg     <= 8'h00;
			hdr_reg     <= '0;
		end
		else if (char_v)
		begin
			if (char_c == CH_DOLLAR)
			begin
				in_sent_reg <= 1'b1;
				star_reg    <= 1'b0;
				hex_cnt_reg <= 2'h0;
				sum_reg     <= 8'h00;
				fld_reg     <= 5'h00;
				pos_reg     <= 7'h00;
				len_reg     <= 8'h01;
			end
			else if (in_sent_reg)
			begin
				if (len_reg < 8'(LT_LEN))
					len_reg <= len_reg + 1'b1;
				if (is_end)
					in_sent_reg <= 1'b0;
				else if (char_c == CH_STAR)
					star_reg <= 1'b1;
				else if (star_reg)
				begin
					if (hex_cnt_reg != 2'h2)
					begin
						rx_sum_reg  <= {rx_sum_reg[3:0], hex_val};
						hex_cnt_reg <= hex_cnt_reg + 1'b1;
					end
				end
				else
				begin
					sum_reg <= sum_reg ^ char_c;
					if (char_c == CH_COMMA)
					begin
						fld_reg <= fld_reg + 1'b1;
						pos_reg <= 7'h00;
					end
					else
					begin
						if (pos_reg != 7'h7f)
							pos_reg <= pos_reg + 1'b1;
						if (fld_reg == 5'h00 && pos_reg < 7'(HDR_LEN))
							hdr_reg <= {hdr_reg[HDR_LEN*8-9:0], char_c};
					end
				end
			end
		end
	end

	// -------------------------------------------------------------
	// Location text: stage the line, copy it on a passed match.
	// -------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			line_reg   <= '0;
			lt_reg     <= '0;
			lt_len_reg <= '0;
		end
		else
		begin
			if (char_v && char_c == CH_DOLLAR)
				line_reg[0] <= char_c;
			else if (char_v && in_sent_reg && !is_end
			         && len_reg < 8'(LT_LEN))
				line_reg[len_reg[6:0]] <= char_c;
			for (int i = 0; i < LT_SLOTS; i++)
			begin
				if (is_end && pass && hdr_in[i] != '0
				    && hdr_in[i] == hdr_reg)
				begin
					lt_reg[i]     <= line_reg;
					lt_len_reg[i] <= len_reg;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			lt_data_out   <= 8'h00;
			lt_len_out    <= 8'h00;
			sent_pass_out <= 1'b0;
			sent_drop_out <= 1'b0;
		end
		else
		begin
			lt_data_out   <= lt_reg[lt_sel_in][lt_idx_in];
			lt_len_out    <= lt_len_reg[lt_sel_in];
			sent_pass_out <= is_end && pass;
			sent_drop_out <= is_end && !pass;
		end
	end

	// -------------------------------------------------------------
	// Time extraction.
	// -------------------------------------------------------------
	stype_t stype;
	logic   stype_ok;
	always_comb
	begin
		stype    = ST_GGA;
		stype_ok = 1'b1;
		unique case (hdr_reg[23:0])
			24'h474741: stype = ST_GGA;
			24'h474c4c: stype = ST_GLL;
			24'h524d43: stype = ST_RMC;
			24'h5a4441: stype = ST_ZDA;
			default:    stype_ok = 1'b0;
		endcase
	end

	wire body = char_v && in_sent_reg && !star_reg && !is_end
	            && char_c != CH_COMMA && char_c != CH_DOLLAR;
	wire [4:0] tfld = (stype == ST_GLL) ? FLD_TIME_GLL : FLD_TIME;
	wire [4:0] vfld = (stype == ST_RMC) ? FLD_FLAG_RMC : FLD_FLAG_GX;
	wire t_dig = body && fld_reg == tfld && pos_reg < 7'(DIGITS);
	wire d_dig = body && ((stype == ST_RMC && fld_reg == FLD_DATE_RMC
	             && pos_reg < 7'(DIGITS)) || (stype == ST_ZDA
	             && ((fld_reg >= FLD_DAY_ZDA && fld_reg < FLD_YEAR_ZDA
	             && pos_reg < 7'h02) || (fld_reg == FLD_YEAR_ZDA
	             && pos_reg >= 7'h02 && pos_reg < 7'h04))));

	// ZDA never has a flag; a GLL without one counts as valid.
	logic flag_ok;
	always_comb
	begin
		if (stype == ST_ZDA)
			flag_ok = 1'b1;
		else if (!flag_seen_reg)
			flag_ok = (stype == ST_GLL);
		else if (stype == ST_GGA)
			flag_ok = (flag_reg != CH_ZERO);
		else
			flag_ok = (flag_reg == CH_A);
	end

	// Checksum failure blocks time even when the filter is off.
	wire take = is_end && sum_ok && stype_ok && tcnt_reg == DIGITS
	            && stype == time_cfg_reg.src
	            && (time_cfg_reg.mode == TM_ON
	                || (time_cfg_reg.mode == TM_VALID && flag_ok));
	wire fresh = time_reg != last_time_reg;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			time_reg      <= 24'h000000;
			date_reg      <= 24'h000000;
			tcnt_reg      <= 3'h0;
			dcnt_reg      <= 3'h0;
			flag_seen_reg <= 1'b0;
			flag_reg      <= 8'h00;
		end
		else if (char_v && char_c == CH_DOLLAR)
		begin
			tcnt_reg      <= 3'h0;
			dcnt_reg      <= 3'h0;
			flag_seen_reg <= 1'b0;
		end
		else
		begin
			if (t_dig)
			begin
				time_reg <= {time_reg[19:0], char_c[3:0]};
				tcnt_reg <= tcnt_reg + 1'b1;
			end
			if (d_dig)
			begin
				date_reg <= {date_reg[19:0], char_c[3:0]};
				dcnt_reg <= dcnt_reg + 1'b1;
			end
			if (body && fld_reg == vfld && pos_reg == 7'h00)
			begin
				flag_seen_reg <= 1'b1;
				flag_reg      <= char_c;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			last_time_reg    <= 24'h000000;
			clk_set_out      <= 1'b0;
			clk_date_set_out <= 1'b0;
			clk_time_out     <= '0;
		end
		else
		begin
			clk_set_out      <= take && fresh;
			clk_date_set_out <= take && fresh && dcnt_reg == DIGITS
			                    && (stype == ST_RMC || stype == ST_ZDA);
			if (take)
				last_time_reg <= time_reg;
			if (take && fresh)
			begin
				clk_time_out.hhmmss <= time_reg;
				if (dcnt_reg == DIGITS && stype != ST_GGA && stype != ST_GLL)
					clk_time_out.ddmmyy <= date_reg;
			end
		end
	end

	// -------------------------------------------------------------
	// Assertions.
	// -------------------------------------------------------------
	AST_PTT_ROLE: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(port_cfg_reg.rate == RATE_OFF) |->
		ptt_inhibit_out == aux_carrier_input_in)
		else $error("Carrier pin does not gate keying at rate zero.");
	AST_RX_OFF: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(port_cfg_reg.rate == RATE_OFF) |=> !uart_v)
		else $error("Receiver enabled with rate zero.");
	AST_RESET_CFG: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$past(!nrst_in) |-> port_cfg_reg == PORT_CFG_RST)
		else $error("Port setup not at default after reset.");
	AST_HOST_SRC: assert property (@(posedge clk_in) disable iff (!nrst_in)
		host_gps_mode_in |-> char_v == prim_char_valid_in && !uart_en)
		else $error("Host GPS mode not reading the primary port.");
	AST_DROP_BAD: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(is_end && !sum_ok && !port_cfg_reg.skip_sum_check)
		|=> sent_drop_out && !sent_pass_out)
		else $error("Sentence with failing checksum was passed.");
	AST_TIME_BAD_SUM: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(is_end && !sum_ok) |=> !clk_set_out)
		else $error("Clock loaded from failing checksum.");
	AST_TIME_OFF: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$past(time_cfg_reg.mode == TM_OFF) |-> !clk_set_out)
		else $error("Clock loaded with acquisition off.");
	AST_SAME_TIME: assert property (@(posedge clk_in) disable iff (!nrst_in)
		clk_set_out |-> clk_time_out.hhmmss != $past(last_time_reg))
		else $error("Clock loaded with repeated time.");
	AST_NO_DATE: assert property (@(posedge clk_in) disable iff (!nrst_in)
		($past(stype == ST_GGA || stype == ST_GLL) && clk_set_out)
		|-> !clk_date_set_out && $stable(clk_time_out.ddmmyy))
		else $error("Date changed from a sentence without date.");
endmodule : gps_serial_time_receiver
`default_nettype wire

/* gps_unit_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_unit_model
#(
	parameter int BIT = 16
)
(
	input  wire logic	clk_in,		// Bench clock
	input  wire logic	inv_in,		// Inverted line sense
	output logic		line_out	// Serial line to the pin
);
	logic	mark_reg = 1'b1;

	// A mark drives the pin low in normal sense, high when inverted.
	assign line_out = mark_reg ^ ~inv_in;

	// ----------------------------------------------------------------
	// Transmit only: the unit is set up beforehand and never listens.
	// ----------------------------------------------------------------
	task automatic send(input string s, input int gap);
		logic [9:0]	fr;
		for (int i = 0; i < s.len(); i++)
		begin
			fr = {1'b1, s[i], 1'b0};
			for (int b = 0; b < 10; b++)
			begin
				mark_reg <= fr[b];
				repeat (BIT) @(posedge clk_in);
			end
			repeat (gap) @(posedge clk_in);
		end
	endtask : send
endmodule : gps_unit_model
`default_nettype wire

/* tb_gps_serial_time_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_gps_serial_time_receiver;
	import gps_pkg::*;
	localparam int BIT = 16;
	logic			clk_in = 1'b0;
	logic			nrst_in = 1'b0;
	logic			aux_line;
	logic			inv = 1'b0;
	aux_gps_port_config_t	port_cfg_in = '0;
	time_acquire_mode_t	time_cfg_in = '0;
	logic			cfg_load_in = 1'b0;
	logic			host_gps_mode_in = 1'b0;
	logic			prim_char_valid_in = 1'b0;
	logic [7:0]		prim_char_in = 8'h00;
	logic [LT_SLOTS-1:0][HDR_LEN*8-1:0] hdr_in = '0;
	logic [7:0]		lt_data_out;
	logic [7:0]		lt_len_out;
	logic			ptt_inhibit_out;
	logic			sent_pass_out;
	logic			sent_drop_out;
	logic			clk_set_out;
	logic			clk_date_set_out;
	gps_time_t		clk_time_out;
	aux_gps_port_config_t	port_cfg_out;
	time_acquire_mode_t	time_cfg_out;
	int			fails = 0;
	int			n_checks = 0;
	int			n_pass = 0, n_drop = 0, n_set = 0, n_date = 0;
	logic [31:0]		seed = 32'd27522;
	logic [23:0]		tb_b;
	string			s_last;

	always #2.5 clk_in = ~clk_in;

	gps_serial_time_receiver #(.BIT_CYC_300(BIT), .BIT_CYC_600(BIT),
		.BIT_CYC_1200(BIT), .BIT_CYC_2400(BIT), .BIT_CYC_4800(BIT))
	gps_serial_time_receiver_inst (.clk_in(clk_in), .nrst_in(nrst_in),
		.aux_carrier_input_in(aux_line), .port_cfg_in(port_cfg_in),
		.time_cfg_in(time_cfg_in), .cfg_load_in(cfg_load_in),
		.host_gps_mode_in(host_gps_mode_in),
		.prim_char_valid_in(prim_char_valid_in),
		.prim_char_in(prim_char_in), .hdr_in(hdr_in),
		.lt_sel_in(2'h0), .lt_idx_in(7'h00),
		.ptt_inhibit_out(ptt_inhibit_out), .lt_data_out(lt_data_out),
		.lt_len_out(lt_len_out), .sent_pass_out(sent_pass_out),
		.sent_drop_out(sent_drop_out), .clk_set_out(clk_set_out),
		.clk_date_set_out(clk_date_set_out),
		.clk_time_out(clk_time_out), .port_cfg_out(port_cfg_out),
		.time_cfg_out(time_cfg_out));

	gps_unit_model #(.BIT(BIT)) gps_unit_model_inst (.clk_in(clk_in),
		.inv_in(inv), .line_out(aux_line));

	// Pulses are tallied so their exact cycle does not matter here.
	always @(posedge clk_in)
	begin
		if (sent_pass_out === 1'b1) n_pass <= n_pass + 1;
		if (sent_drop_out === 1'b1) n_drop <= n_drop + 1;
		if (clk_set_out === 1'b1) n_set <= n_set + 1;
		if (clk_date_set_out === 1'b1) n_date <= n_date + 1;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_cnt(input int got, input int exp);
		chk_val(48'(got), 48'(exp));
	endtask : chk_cnt

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Kind 0 is a good sum, 1 a corrupted sum, 2 no sum at all.
	function automatic string nmea(input string body, input int k);
		logic [7:0]	x;
		x = 8'h00;
		for (int i = 0; i < body.len(); i++)
			x ^= body[i];
		if (k == 2)
			return {"$", body, "\r\n"};
		return {"$", body, "*", $sformatf("%02X", x ^ 8'(k)), "\r\n"};
	endfunction : nmea

	task automatic cfg(input rate_t r, input logic iv, input logic sk,
		input tmode_t m, input stype_t src);
		port_cfg_in <= '{r, iv, sk};
		time_cfg_in <= '{m, src};
		cfg_load_in <= 1'b1;
		@(posedge clk_in);
		cfg_load_in <= 1'b0;
		@(posedge clk_in);
		chk_val(48'({port_cfg_out, time_cfg_out}),
			48'({r, iv, sk, m, src}));
	endtask : cfg

	// Digits 1..9 only, so a fresh time never equals the reset last time 000000.
	task automatic go(input bit aux, input string pre, input string post,
		input int k, input int gap);
		string	t;
		logic [3:0]	d;
		t = "";
		for (int i = 0; i < 6; i++)
		begin
			d = 4'(rnd() % 9 + 1);
			t = {t, $sformatf("%0d", d)};
			tb_b = {tb_b[19:0], d};
		end
		s_last = nmea({pre, t, post}, k);
		if (aux)
			gps_unit_model_inst.send(s_last, gap);
		else
			host_send(s_last);
	endtask : go

	task automatic host_send(input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			prim_char_in <= s[i];
			prim_char_valid_in <= 1'b1;
			@(posedge clk_in);
		end
		prim_char_valid_in <= 1'b0;
	endtask : host_send

	task automatic sent_check(input int p, input int d, input int s,
		input int dt);
		repeat (4) @(posedge clk_in);
		chk_cnt(n_pass, p);
		chk_cnt(n_drop, d);
		chk_cnt(n_set, s);
		chk_cnt(n_date, dt);
		n_pass = 0;
		n_drop = 0;
		n_set = 0;
		n_date = 0;
	endtask : sent_check

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (80000) @(posedge clk_in);
		fails++;
		wrap_up();
	end

	initial
	begin
		hdr_in[0] = 40'h4750524d43;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		chk_val(48'({port_cfg_out, time_cfg_out}),
			48'({RATE_OFF, 2'b00, TM_VALID, ST_RMC}));
		chk_val(48'(ptt_inhibit_out), 48'h0);
		inv <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk_val(48'(ptt_inhibit_out), 48'h1);
		inv <= 1'b0;
		host_gps_mode_in <= 1'b1;
		cfg(RATE_OFF, 1'b0, 1'b0, TM_VALID, ST_RMC);
		go(0, "GPRMC,", ",A,,,,,,,230394", 0, 0);
		sent_check(1, 0, 1, 1);
		chk_val(clk_time_out, {tb_b, 24'h230394});
		chk_val({lt_len_out, lt_data_out},
			{8'(s_last.len() - 2), CH_DOLLAR});
		host_send(s_last);
		sent_check(1, 0, 0, 0);
		go(0, "GPRMC,", ",V,,,,,,,230394", 0, 0);
		sent_check(1, 0, 0, 0);
		cfg(RATE_OFF, 1'b0, 1'b0, TM_ON, ST_RMC);
		go(0, "GPRMC,", ",V,,,,,,,230394", 0, 0);
		sent_check(1, 0, 1, 1);
		go(0, "GPRMC,", ",A,,,,,,,230394", 1, 0);
		sent_check(0, 1, 0, 0);
		cfg(RATE_OFF, 1'b0, 1'b1, TM_ON, ST_RMC);
		go(0, "GPRMC,", ",A,,,,,,,230394", 1, 0);
		sent_check(1, 0, 0, 0);
		cfg(RATE_OFF, 1'b0, 1'b0, TM_ON, ST_RMC);
		go(0, "GPRMC,", ",A,,,,,,,230394", 2, 0);
		sent_check(1, 0, 1, 1);
		cfg(RATE_OFF, 1'b0, 1'b0, TM_OFF, ST_RMC);
		go(0, "GPRMC,", ",A,,,,,,,230394", 0, 0);
		sent_check(1, 0, 0, 0);
		cfg(RATE_OFF, 1'b0, 1'b0, TM_ON, ST_GGA);
		go(0, "GPGGA,", ",,,,,0", 0, 0);
		sent_check(1, 0, 1, 0);
		chk_val(clk_time_out, {tb_b, 24'h230394});
		cfg(RATE_OFF, 1'b0, 1'b0, TM_VALID, ST_GLL);
		go(0, "GPGLL,,,,,", "", 0, 0);
		sent_check(1, 0, 1, 0);
		cfg(RATE_OFF, 1'b0, 1'b0, TM_VALID, ST_ZDA);
		go(0, "GPZDA,", ",23,03,1994", 0, 0);
		sent_check(1, 0, 1, 1);
		host_gps_mode_in <= 1'b0;
		for (int r = 1; r < 6; r++)
		begin
			cfg(RATE_OFF, 1'b0, 1'b0, TM_ON, ST_RMC);
			inv <= r[0];
			repeat (4) @(posedge clk_in);
			cfg(rate_t'(r), r[0], 1'b0, TM_ON, ST_RMC);
			chk_val(48'(ptt_inhibit_out), 48'h0);
			go(1, "GPRMC,", ",A,,,,,,,230394", 0, r * 4);
			sent_check(1, 0, 1, 1);
			chk_val(clk_time_out, {tb_b, 24'h230394});
		end
		cfg(RATE_OFF, 1'b0, 1'b0, TM_ON, ST_RMC);
		go(1, "GPRMC,", ",A,,,,,,,230394", 0, 0);
		sent_check(0, 0, 0, 0);
		inv <= 1'b0;
		repeat (4) @(posedge clk_in);
		host_gps_mode_in <= 1'b1;
		cfg(RATE_4800, 1'b0, 1'b0, TM_ON, ST_RMC);
		go(1, "GPRMC,", ",A,,,,,,,230394", 0, 0);
		sent_check(0, 0, 0, 0);
		wrap_up();
	end
endmodule : tb_gps_serial_time_receiver
`default_nettype wire
